//--- rtl/baud_pkg.sv
package baud_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] DIV_LOW_ADDR = 8'h00;
  localparam logic [7:0] DIV_HIGH_ADDR = 8'h04;
  localparam logic [7:0] TX_STAT_CTRL_ADDR = 8'h08;
  localparam logic [7:0] BAUD_CTRL_ADDR = 8'h0c;
  localparam logic [7:0] COUNT_STATUS_ADDR = 8'h10;

  // field positions
  localparam int SYNC_SELECT_BIT = 4;
  localparam int HIGH_SPEED_SELECT_BIT = 2;
  localparam int WIDE_DIVISOR_SELECT_BIT = 3;

  // reset values
  localparam logic [7:0] DIV_LOW_RESET = 8'h00;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic CTRL_BIT_RESET = 1'b0;

  // prescale ratios ahead of the divisor counter
  localparam int unsigned PRE_4 = 4;
  localparam int unsigned PRE_16 = 16;
  localparam int unsigned PRE_64 = 64;

  typedef enum logic [1:0] {
    RATIO_4 = 2'b00,
    RATIO_16 = 2'b01,
    RATIO_64 = 2'b10
  } ratio_e;

endpackage : baud_pkg

//--- rtl/prescale_if.sv
interface prescale_if;
  logic restart;
  baud_pkg::ratio_e ratio;
  logic tick;

  modport ctrl (output restart, output ratio, input tick);
  modport presc (input restart, input ratio, output tick);
endinterface : prescale_if

//--- rtl/baud_prescaler.sv
module baud_prescaler #(
  parameter int unsigned MAX_RATIO = 64
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the divisor counter
  prescale_if.presc pre
);

  localparam int CW = $clog2(MAX_RATIO);

  if (MAX_RATIO < baud_pkg::PRE_64) begin : g_check
    $error("prescaler cannot reach the largest ratio");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] last;
  logic tick_reg;

  always_comb begin
    case (pre.ratio)
      baud_pkg::RATIO_4: last = CW'(baud_pkg::PRE_4 - 1);
      baud_pkg::RATIO_16: last = CW'(baud_pkg::PRE_16 - 1);
      default: last = CW'(baud_pkg::PRE_64 - 1);
    endcase
  end

  // a restart clears the phase so the first tick is one full ratio away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (pre.restart) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
      tick_reg <= 1'b0;
    end
  end

  assign pre.tick = tick_reg;

endmodule : baud_prescaler

//--- rtl/baud_rate_generator.sv
// Summary of operation
// - high divisor byte: bits 15:8, rw, reset zero
// - high byte ignored unless wide divisor select
// - high byte write restarts the counter
// - divisor is high byte above low byte
// - async, narrow, low speed: divide 64(n+1)
// - async, wide, low speed: divide 16(n+1)
// - sync mode: divide 4(n+1), speed ignored
// - unimplemented control bits read as zero
// - wide select set picks 16-bit divisor
// - speed select only matters when asynchronous
// - sync select set means synchronous mode
// - low byte write restarts the counter
//
// The address map and the APB slave port are this design's own decisions.
module baud_rate_generator #(
  parameter int unsigned DIV_WIDTH = 16,
  parameter int unsigned ADDR_WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bit timing
  output logic bit_tick,
  output logic sync_mode
);

  if (DIV_WIDTH != 16 || ADDR_WIDTH < 8) begin : g_check
    $error("divisor must be 16 bits and address at least 8 bits");
  end

  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic sync_select_reg;
  logic high_speed_select_reg;
  logic wide_divisor_select_reg;
  logic [DIV_WIDTH-1:0] count_reg;
  logic restart_reg;
  logic bit_tick_reg;
  logic sync_mode_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic [DIV_WIDTH-1:0] n_value;
  logic [7:0] addr8;
  logic setup_phase;
  logic access_done;
  logic wr_low;
  logic wr_high;
  logic wr_tsc;
  logic wr_bc;
  logic [31:0] rdata_next;
  logic err_next;
  baud_pkg::ratio_e ratio_sel;

  prescale_if pre ();

  baud_prescaler #(
    .MAX_RATIO(baud_pkg::PRE_64)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .pre(pre)
  );

  // bus decode; upper address bits must be zero for a hit
  assign addr8 = paddr[7:0];
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign wr_low = access_done && pwrite && !pslverr_reg
                  && addr8 == baud_pkg::DIV_LOW_ADDR;
  assign wr_high = access_done && pwrite && !pslverr_reg
                   && addr8 == baud_pkg::DIV_HIGH_ADDR;
  assign wr_tsc = access_done && pwrite && !pslverr_reg
                  && addr8 == baud_pkg::TX_STAT_CTRL_ADDR;
  assign wr_bc = access_done && pwrite && !pslverr_reg
                 && addr8 == baud_pkg::BAUD_CTRL_ADDR;

  // narrow mode ignores the high byte entirely
  assign n_value = wide_divisor_select_reg ?
                   {div_high_reg, div_low_reg} :
                   {8'h00, div_low_reg};

  // prescale choice; speed select is only looked at when asynchronous
  always_comb begin
    if (sync_select_reg) begin
      ratio_sel = baud_pkg::RATIO_4;
    end else if (!wide_divisor_select_reg && !high_speed_select_reg) begin
      ratio_sel = baud_pkg::RATIO_64;
    end else if (wide_divisor_select_reg && high_speed_select_reg) begin
      ratio_sel = baud_pkg::RATIO_4;
    end else begin
      ratio_sel = baud_pkg::RATIO_16;
    end
  end

  assign pre.ratio = ratio_sel;
  assign pre.restart = restart_reg;

  // read data is built in the setup cycle so prdata is a flop output
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr[ADDR_WIDTH-1:0] != ADDR_WIDTH'(addr8)) begin
      err_next = 1'b1;
    end else if (addr8 == baud_pkg::DIV_LOW_ADDR) begin
      rdata_next[7:0] = div_low_reg;
    end else if (addr8 == baud_pkg::DIV_HIGH_ADDR) begin
      rdata_next[7:0] = div_high_reg;
    end else if (addr8 == baud_pkg::TX_STAT_CTRL_ADDR) begin
      // only the two bits kept here exist; the rest read zero
      rdata_next[baud_pkg::SYNC_SELECT_BIT] = sync_select_reg;
      rdata_next[baud_pkg::HIGH_SPEED_SELECT_BIT] = high_speed_select_reg;
    end else if (addr8 == baud_pkg::BAUD_CTRL_ADDR) begin
      rdata_next[baud_pkg::WIDE_DIVISOR_SELECT_BIT] =
        wide_divisor_select_reg;
    end else if (addr8 == baud_pkg::COUNT_STATUS_ADDR) begin
      rdata_next[DIV_WIDTH-1:0] = count_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // one access cycle per transfer: ready follows the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      pready_reg <= 1'b1;
      pslverr_reg <= err_next;
    end else begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low_reg <= baud_pkg::DIV_LOW_RESET;
      div_high_reg <= baud_pkg::DIV_HIGH_RESET;
    end else begin
      if (wr_low) begin
        div_low_reg <= pwdata[7:0];
      end
      if (wr_high) begin
        div_high_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_select_reg <= baud_pkg::CTRL_BIT_RESET;
      high_speed_select_reg <= baud_pkg::CTRL_BIT_RESET;
      wide_divisor_select_reg <= baud_pkg::CTRL_BIT_RESET;
    end else begin
      if (wr_tsc) begin
        sync_select_reg <= pwdata[baud_pkg::SYNC_SELECT_BIT];
        high_speed_select_reg <= pwdata[baud_pkg::HIGH_SPEED_SELECT_BIT];
      end
      if (wr_bc) begin
        wide_divisor_select_reg <=
          pwdata[baud_pkg::WIDE_DIVISOR_SELECT_BIT];
      end
    end
  end

  // the restart is delayed a cycle so the new byte is already stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_low || wr_high;
    end
  end

  // mode changes do not restart; the new ratio applies from the next tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      bit_tick_reg <= 1'b0;
    end else if (restart_reg) begin
      count_reg <= n_value;
      bit_tick_reg <= 1'b0;
    end else if (pre.tick) begin
      if (count_reg == '0) begin
        count_reg <= n_value;
        bit_tick_reg <= 1'b1;
      end else begin
        count_reg <= count_reg - DIV_WIDTH'(1);
        bit_tick_reg <= 1'b0;
      end
    end else begin
      bit_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_mode_reg <= 1'b0;
    end else begin
      sync_mode_reg <= sync_select_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bit_tick = bit_tick_reg;
  assign sync_mode = sync_mode_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  high_byte_wr_a: assert property (
    wr_high |=> div_high_reg == $past(pwdata[7:0])
  ) else $error("high divisor byte not stored");

  narrow_high_a: assert property (
    !wide_divisor_select_reg |-> n_value[15:8] == 8'h00
  ) else $error("high byte used in narrow mode");

  high_restart_a: assert property (
    wr_high |=> restart_reg ##1 count_reg == $past(n_value)
  ) else $error("high byte write did not restart");

  n_concat_a: assert property (
    wide_divisor_select_reg |-> n_value == {div_high_reg, div_low_reg}
  ) else $error("divisor not formed from both bytes");

  async_slow_a: assert property (
    !sync_select_reg && !wide_divisor_select_reg && !high_speed_select_reg
    |-> pre.ratio == baud_pkg::RATIO_64
  ) else $error("slow narrow async ratio wrong");

  async_wide_a: assert property (
    !sync_select_reg && wide_divisor_select_reg && !high_speed_select_reg
    |-> pre.ratio == baud_pkg::RATIO_16
  ) else $error("slow wide async ratio wrong");

  sync_ratio_a: assert property (
    sync_select_reg |-> pre.ratio == baud_pkg::RATIO_4
  ) else $error("sync ratio wrong");

  unimpl_zero_a: assert property (
    access_done && !pwrite && addr8 == baud_pkg::BAUD_CTRL_ADDR
    |-> prdata_reg[31:4] == 28'h0 && prdata_reg[2:0] == 3'h0
  ) else $error("unimplemented bits read nonzero");

  low_restart_a: assert property (
    wr_low |=> restart_reg
  ) else $error("low byte write did not restart");

  reload_pulse_a: assert property (
    pre.tick && !restart_reg && count_reg == '0
    |=> bit_tick_reg && count_reg == $past(n_value)
  ) else $error("no reload and pulse at zero");

  pulse_cause_a: assert property (
    bit_tick_reg |-> $past(pre.tick) && $past(count_reg) == '0
  ) else $error("bit pulse without terminal count");

  fast_narrow_a: assert property (
    !sync_select_reg && !wide_divisor_select_reg && high_speed_select_reg
    |-> pre.ratio == baud_pkg::RATIO_16
  ) else $error("fast narrow async ratio wrong");

  fast_wide_a: assert property (
    !sync_select_reg && wide_divisor_select_reg && high_speed_select_reg
    |-> pre.ratio == baud_pkg::RATIO_4
  ) else $error("fast wide async ratio wrong");

  narrow_low_a: assert property (
    !wide_divisor_select_reg |-> n_value == {8'h00, div_low_reg}
  ) else $error("narrow divisor not the low byte");

  sync_follow_a: assert property (
    sync_mode_reg == $past(sync_select_reg)
  ) else $error("sync mode output stale");

  // a restart must also drop any tick already under way
  restart_phase_a: assert property (
    restart_reg |=> !pre.tick && !bit_tick_reg
  ) else $error("restart did not clear the phase");

  low_byte_wr_a: assert property (
    wr_low |=> div_low_reg == $past(pwdata[7:0])
  ) else $error("low divisor byte not stored");

endmodule : baud_rate_generator

//--- dv/uart_baud_rate_generator_tb.sv
module uart_baud_rate_generator_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bit_tick;
  logic sync_mode;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 pclk = ~pclk;

  baud_rate_generator DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bit_tick(bit_tick),
    .sync_mode(sync_mode)
  );

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // the whole run needs about 20000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // an idle edge closes each transfer so psel is never set twice at one edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(w, 32'h1, "ready wait");
    @(posedge pclk);
    chk({31'h0, pready}, 32'h0, "ready dropped");
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, "read data");
    chk({31'h0, err}, 32'h0, "read error");
  endtask : rdchk

  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bit_tick !== 1'b1);
  endtask : wait_tick

  function automatic int period(bit s, bit w, bit f, int hi, int lo);
    int n;
    int p;
    n = w ? hi * 256 + lo : lo;
    p = s ? baud_pkg::PRE_4 : w ? (f ? baud_pkg::PRE_4 : baud_pkg::PRE_16)
      : (f ? baud_pkg::PRE_16 : baud_pkg::PRE_64);
    return p * (n + 1);
  endfunction : period

  task test_regs;
    rdchk(baud_pkg::DIV_LOW_ADDR, 32'h0000_0000);
    rdchk(baud_pkg::DIV_HIGH_ADDR, 32'h0000_0000);
    rdchk(baud_pkg::TX_STAT_CTRL_ADDR, 32'h0000_0000);
    rdchk(baud_pkg::BAUD_CTRL_ADDR, 32'h0000_0000);
    apb(1'b1, baud_pkg::DIV_HIGH_ADDR, 32'hffff_ffa5);
    rdchk(baud_pkg::DIV_HIGH_ADDR, 32'h0000_00a5);
    apb(1'b1, baud_pkg::BAUD_CTRL_ADDR, 32'hffff_ffff);
    rdchk(baud_pkg::BAUD_CTRL_ADDR, 32'h0000_0008);
    apb(1'b1, baud_pkg::TX_STAT_CTRL_ADDR, 32'hffff_ffff);
    rdchk(baud_pkg::TX_STAT_CTRL_ADDR, 32'h0000_0014);
    chk({31'h0, sync_mode}, 32'h1, "sync level");
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, 8'h01, 32'h0000_00ff);
    chk({31'h0, err}, 32'h1, "unaligned error");
    rdchk(baud_pkg::DIV_LOW_ADDR, 32'h0000_0000);
  endtask : test_regs

  // mode set first, low byte last so the count starts on the new divisor
  task test_rate(input bit s, input bit w, input bit f, input int hi,
      input int lo);
    int n;
    apb(1'b1, baud_pkg::TX_STAT_CTRL_ADDR, {27'h0, s, 1'b0, f, 2'b00});
    apb(1'b1, baud_pkg::BAUD_CTRL_ADDR, {28'h0, w, 3'b000});
    apb(1'b1, baud_pkg::DIV_HIGH_ADDR, hi);
    apb(1'b1, baud_pkg::DIV_LOW_ADDR, lo);
    wait_tick(n);
    wait_tick(n);
    chk(n, period(s, w, f, hi, lo), "tick period");
    wait_tick(n);
    chk(n, period(s, w, f, hi, lo), "tick period");
    chk({31'h0, sync_mode}, {31'h0, s}, "sync level");
  endtask : test_rate

  // equal delays from writes made at different phases prove the restart
  task test_restart;
    int d1;
    int d2;
    int n;
    wait_tick(n);
    repeat (37) @(posedge pclk);
    apb(1'b1, baud_pkg::DIV_HIGH_ADDR, 32'h0000_0007);
    wait_tick(d1);
    wait_tick(n);
    repeat (101) @(posedge pclk);
    apb(1'b1, baud_pkg::DIV_LOW_ADDR, 32'h0000_0003);
    wait_tick(d2);
    chk(d2, d1, "restart delay");
    wait_tick(n);
    chk(n, 256, "period after restart");
    // the count was just reloaded and holds n for a whole prescale step
    rdchk(baud_pkg::COUNT_STATUS_ADDR, 32'h0000_0003);
  endtask : test_restart

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_rate(1'b0, 1'b0, 1'b0, 5, 2);
    test_rate(1'b0, 1'b1, 1'b0, 1, 2);
    test_rate(1'b0, 1'b0, 1'b1, 0, 3);
    test_rate(1'b0, 1'b1, 1'b1, 0, 9);
    test_rate(1'b1, 1'b0, 1'b0, 0, 5);
    test_rate(1'b1, 1'b0, 1'b1, 0, 5);
    test_rate(1'b1, 1'b1, 1'b0, 1, 1);
    test_rate(1'b0, 1'b0, 1'b0, 0, 3);
    test_restart();
    end_of_test();
  end

endmodule : uart_baud_rate_generator_tb
